/* File: design/uhri_top.sv */
// Register front end of the serial port: classic Wishbone slave, interrupt logic,
// DMA requests, baud divider and transmit holding stage.
// Assumes a receiver outside delivers characters as one-cycle events.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "uhri_params.svh"

module uhri_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receiver and modem lines.
  input wire uhri_pkg::uhri_rx_event_type rx_evt_i,
  input wire uhri_pkg::uhri_modem_type modem_i,
  // Serial output, interrupt and DMA requests.
  output logic txd_o,
  output logic irq_o,
  output logic rx_dma_req_o,
  output logic tx_dma_req_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte lanes 0 and 1 carry a 16-bit register; lanes 2 and 3 are ignored.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel,
                                          input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res & mask;
  endfunction

  // A divider of zero is treated as one so the bit timer never stalls.
  function automatic logic [19:0] bit_reload(input logic [15:0] div);
    logic [19:0] eff;
    eff = (div == `UHRI_RST_ZERO) ? {4'h0, `UHRI_RST_DIV} : {4'h0, div};
    return 20'(eff * `UHRI_OVERSAMPLE - 20'h0_0001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  uhri_pkg::uhri_ien_type ien, next_ien;
  logic [15:0] lcr, next_lcr;
  logic [15:0] mcr, next_mcr;
  logic [15:0] scr, next_scr;
  logic [15:0] fbr, next_fbr;
  logic [15:0] div, next_div;
  logic [7:0] tx_hold, next_tx_hold;
  logic hold_full, next_hold_full;
  logic [7:0] rx_buf, next_rx_buf;
  logic rx_full, next_rx_full;
  logic txe_flag, next_txe_flag;
  logic [3:0] line_err, next_line_err;
  logic [3:0] modem_chg, next_modem_chg;
  logic irq, next_irq;
  logic rx_dma, next_rx_dma;
  logic tx_dma, next_tx_dma;
  logic [19:0] bit_cnt, next_bit_cnt;
  logic bit_tick, next_bit_tick;

  logic access;
  logic wr;
  logic rd;
  logic data_wr;
  logic div_wr;
  logic tx_busy;
  logic tx_load;
  logic pending;
  uhri_pkg::uhri_cause_type cause;
  logic [15:0] identify;
  logic [15:0] lsr_view;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter.

  // The holding stage hands over whenever the shifter is idle.
  assign tx_load = hold_full & ~tx_busy;

  uhri_tx_serial uhri_tx_serial_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bit_tick_i(bit_tick),
    .load_i(tx_load),
    .char_i(tx_hold),
    .txd_o(txd_o),
    .busy_o(tx_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Baud divider: one bit period is sixteen sample periods of baud_divider clocks.

  always_comb begin
    next_bit_tick = 1'b0;
    next_bit_cnt = bit_cnt - 20'h0_0001;
    if (bit_cnt == 20'h0_0000) begin
      next_bit_cnt = bit_reload(div);
      next_bit_tick = 1'b1;
    end
    // A new divider value restarts the bit timer, so a slow old rate cannot linger.
    if (div_wr) begin
      next_bit_cnt = bit_reload(next_div);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt <= 20'h0_0000;
      bit_tick <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      bit_tick <= next_bit_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt identification.

  always_comb begin
    // Only the highest-priority enabled cause is reported; the others wait behind it.
    pending = 1'b1;
    cause = uhri_pkg::CAUSE_MODEM;
    if (ien.line_irq_enable && (line_err != `UHRI_RST_NIBBLE)) begin
      cause = uhri_pkg::CAUSE_LINE;
    end else if (ien.rx_full_irq_enable && rx_full) begin
      cause = uhri_pkg::CAUSE_RX_FULL;
    end else if (ien.tx_empty_irq_enable && txe_flag) begin
      cause = uhri_pkg::CAUSE_TX_EMPTY;
    end else if (ien.modem_irq_enable && (modem_chg != `UHRI_RST_NIBBLE)) begin
      cause = uhri_pkg::CAUSE_MODEM;
    end else begin
      pending = 1'b0;
    end
    identify = {13'h0000, cause, ~pending};
    // Line status view: both transmit stages empty in bit 6, holding stage empty in bit 5, errors in 4:1.
    lsr_view = {9'h000, ~hold_full & ~tx_busy, ~hold_full, line_err, rx_full};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus access and register file.

  // A request is not taken in its ack cycle, so a held strobe is not taken twice.
  assign access = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = access & wb_we_i;
  assign rd = access & ~wb_we_i;
  // A character write that lands while the shifter takes the old one keeps the stage full.
  assign data_wr = wr & (wb_adr_i == `UHRI_ADR_DATA) & wb_sel_i[0];
  assign div_wr = wr & (wb_adr_i == `UHRI_ADR_DIV);

  always_comb begin
    next_ack = access;
    next_rdata = rdata;
    next_ien = ien;
    next_lcr = lcr;
    next_mcr = mcr;
    next_scr = scr;
    next_fbr = fbr;
    next_div = div;
    next_tx_hold = tx_hold;
    next_hold_full = hold_full;
    next_rx_buf = rx_buf;
    next_rx_full = rx_full;
    next_txe_flag = txe_flag;
    next_line_err = line_err;
    next_modem_chg = modem_chg;

    // Register writes.
    if (wr) begin
      case (wb_adr_i)
        `UHRI_ADR_DATA: begin
          if (wb_sel_i[0]) begin
            next_tx_hold = wb_dat_i[7:0];
            next_hold_full = 1'b1;
            next_txe_flag = 1'b0;
          end
        end
        `UHRI_ADR_IEN: next_ien = merge16(ien, wb_dat_i, wb_sel_i, `UHRI_MASK_IEN);
        `UHRI_ADR_LCR: next_lcr = merge16(lcr, wb_dat_i, wb_sel_i, `UHRI_MASK_LCR);
        `UHRI_ADR_MCR: next_mcr = merge16(mcr, wb_dat_i, wb_sel_i, `UHRI_MASK_MCR);
        `UHRI_ADR_SCR: next_scr = merge16(scr, wb_dat_i, wb_sel_i, `UHRI_MASK_FULL);
        `UHRI_ADR_FBR: next_fbr = merge16(fbr, wb_dat_i, wb_sel_i, `UHRI_MASK_FULL);
        `UHRI_ADR_DIV: next_div = merge16(div, wb_dat_i, wb_sel_i, `UHRI_MASK_FULL);
        default: begin
        end
      endcase
    end

    // Register reads and their clearing side effects.
    if (rd) begin
      case (wb_adr_i)
        `UHRI_ADR_DATA: begin
          next_rdata = {24'h00_0000, rx_buf};
          next_rx_full = 1'b0;
        end
        `UHRI_ADR_IEN: next_rdata = {16'h0000, ien};
        `UHRI_ADR_IIR: begin
          next_rdata = {16'h0000, identify};
          if (pending && (cause == uhri_pkg::CAUSE_TX_EMPTY)) begin
            next_txe_flag = 1'b0;
          end
        end
        `UHRI_ADR_LCR: next_rdata = {16'h0000, lcr};
        `UHRI_ADR_MCR: next_rdata = {16'h0000, mcr};
        `UHRI_ADR_LSR: begin
          next_rdata = {16'h0000, lsr_view};
          next_line_err = `UHRI_RST_NIBBLE;
        end
        `UHRI_ADR_MSR: begin
          next_rdata = {24'h00_0000, modem_i.level, modem_chg};
          next_modem_chg = `UHRI_RST_NIBBLE;
        end
        `UHRI_ADR_SCR: next_rdata = {16'h0000, scr};
        `UHRI_ADR_FBR: next_rdata = {16'h0000, fbr};
        `UHRI_ADR_DIV: next_rdata = {16'h0000, div};
        default: next_rdata = `UHRI_ZERO32;
      endcase
    end

    // Hardware events; each set wins over a clear in the same cycle.
    if (tx_load) begin
      next_hold_full = data_wr;
      next_txe_flag = 1'b1;
    end
    if (next_ien.tx_empty_irq_enable && !ien.tx_empty_irq_enable && !hold_full) begin
      next_txe_flag = 1'b1;
    end
    if (rx_evt_i.valid) begin
      next_rx_buf = rx_evt_i.char;
      next_rx_full = 1'b1;
    end
    // A character arriving while the buffer is still full is an overrun.
    next_line_err = next_line_err | {rx_evt_i.brk, rx_evt_i.framing, rx_evt_i.parity,
                                     rx_evt_i.overrun | (rx_evt_i.valid & rx_full)};
    next_modem_chg = next_modem_chg | modem_i.change;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and DMA outputs.

  always_comb begin
    next_irq = pending;
    next_rx_dma = ien.rx_dma_req_enable & rx_full;
    next_tx_dma = ien.tx_dma_req_enable & ~hold_full;
  end

  // Every output pin comes from a flop, so the pins lag the state by one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq <= 1'b0;
      rx_dma <= 1'b0;
      tx_dma <= 1'b0;
    end else begin
      irq <= next_irq;
      rx_dma <= next_rx_dma;
      tx_dma <= next_tx_dma;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus side and control registers.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= `UHRI_ZERO32;
      ien <= `UHRI_RST_ZERO;
      lcr <= `UHRI_RST_ZERO;
      mcr <= `UHRI_RST_ZERO;
      scr <= `UHRI_RST_ZERO;
      fbr <= `UHRI_RST_ZERO;
      div <= `UHRI_RST_DIV;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ien <= next_ien;
      lcr <= next_lcr;
      mcr <= next_mcr;
      scr <= next_scr;
      fbr <= next_fbr;
      div <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding stage.
  // The character waits here while the shifter sends the one before it.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold <= `UHRI_RST_CHAR;
      hold_full <= 1'b0;
      txe_flag <= 1'b0;
    end else begin
      tx_hold <= next_tx_hold;
      hold_full <= next_hold_full;
      txe_flag <= next_txe_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and sticky changes.
  // Line errors and modem changes stay set until their register is read.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf <= `UHRI_RST_CHAR;
      rx_full <= 1'b0;
      line_err <= `UHRI_RST_NIBBLE;
      modem_chg <= `UHRI_RST_NIBBLE;
    end else begin
      rx_buf <= next_rx_buf;
      rx_full <= next_rx_full;
      line_err <= next_line_err;
      modem_chg <= next_modem_chg;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign irq_o = irq;
  assign rx_dma_req_o = rx_dma;
  assign tx_dma_req_o = tx_dma;

endmodule

/* File: design/uhri_tx_serial.sv */
// Transmit shift register: start bit, eight data bits LSB first, one stop bit.
// Assumes one bit period per bit_tick_i pulse and a load only while idle.
`timescale 1ns/1ps
`include "uhri_params.svh"

module uhri_tx_serial (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic bit_tick_i,
  input wire logic load_i,
  input wire logic [7:0] char_i,
  // Line and state.
  output logic txd_o,
  output logic busy_o
);

  uhri_pkg::uhri_tx_state_type state, next_state;
  logic [9:0] shift, next_shift;
  logic [3:0] left, next_left;
  logic txd, next_txd;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_left = left;
    next_txd = txd;
    case (state)
      uhri_pkg::TX_IDLE: begin
        next_txd = 1'b1;
        if (load_i) begin
          next_shift = {1'b1, char_i, 1'b0};
          next_left = `UHRI_FRAME_BITS;
          next_state = uhri_pkg::TX_SHIFT;
        end
      end
      uhri_pkg::TX_SHIFT: begin
        if (bit_tick_i) begin
          if (left == `UHRI_RST_NIBBLE) begin
            next_txd = 1'b1;
            next_state = uhri_pkg::TX_IDLE;
          end else begin
            next_txd = shift[0];
            next_shift = {1'b1, shift[9:1]};
            next_left = left - 4'h1;
          end
        end
      end
      default: begin
        next_state = uhri_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= uhri_pkg::TX_IDLE;
      shift <= 10'h3FF;
      left <= `UHRI_RST_NIBBLE;
      txd <= 1'b1;
    end else begin
      state <= next_state;
      shift <= next_shift;
      left <= next_left;
      txd <= next_txd;
    end
  end

  assign txd_o = txd;
  assign busy_o = (state == uhri_pkg::TX_SHIFT);

endmodule

/* File: pkg/uhri_params.svh */
// Constants of the serial port register front end: addresses, masks, resets, timing.
// Assumes a 32-bit classic Wishbone byte address and a 20 MHz system clock.
`ifndef UHRI_PARAMS_SVH
`define UHRI_PARAMS_SVH

`define UHRI_ADR_DATA 32'h4000_5000
`define UHRI_ADR_IEN 32'h4000_5004
`define UHRI_ADR_IIR 32'h4000_5008
`define UHRI_ADR_LCR 32'h4000_500C
`define UHRI_ADR_MCR 32'h4000_5010
`define UHRI_ADR_LSR 32'h4000_5014
`define UHRI_ADR_MSR 32'h4000_5018
`define UHRI_ADR_SCR 32'h4000_501C
`define UHRI_ADR_FBR 32'h4000_5024
`define UHRI_ADR_DIV 32'h4000_5028

`define UHRI_RST_ZERO 16'h0000
`define UHRI_RST_DIV 16'h0001
`define UHRI_RST_CHAR 8'h00
`define UHRI_RST_NIBBLE 4'h0

`define UHRI_MASK_IEN 16'h003F
`define UHRI_MASK_LCR 16'h007F
`define UHRI_MASK_MCR 16'h001F
`define UHRI_MASK_FULL 16'hFFFF

`define UHRI_OVERSAMPLE 20'h0_0010
`define UHRI_FRAME_BITS 4'hA
`define UHRI_ZERO32 32'h0000_0000

`endif

/* File: pkg/uhri_pkg.sv */
// Types shared by the serial port register front end and its transmit shifter.
// Assumes uhri_params.svh supplies all numeric constants.
package uhri_pkg;

  // Interrupt cause code as reported in irq_identify bits 2:1.
  typedef enum logic [1:0] {
    CAUSE_MODEM = 2'b00,
    CAUSE_TX_EMPTY = 2'b01,
    CAUSE_RX_FULL = 2'b10,
    CAUSE_LINE = 2'b11
  } uhri_cause_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } uhri_tx_state_type;

  // Layout of irq_enable.
  typedef struct packed {
    logic [9:0] reserved;
    logic rx_dma_req_enable;
    logic tx_dma_req_enable;
    logic modem_irq_enable;
    logic line_irq_enable;
    logic tx_empty_irq_enable;
    logic rx_full_irq_enable;
  } uhri_ien_type;

  // One received character with its line errors, from the receiver.
  typedef struct packed {
    logic valid;
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
    logic [7:0] char;
  } uhri_rx_event_type;

  // Modem line changes and current levels.
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] change;
  } uhri_modem_type;

endpackage

/* File: sim/uart_host_regs_and_irq_bench.sv */
// Self-checking bench of the serial port register front end.
// Assumes uhri_monitor and uhri_far_end are compiled before this file.
`timescale 1ns/1ps
`include "uhri_params.svh"

module uart_host_regs_and_irq_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, txd_o, irq_o, rx_dma_req_o, tx_dma_req_o, far_got, far_err;
  uhri_pkg::uhri_rx_event_type rx_evt_i = '0;
  uhri_pkg::uhri_modem_type modem_i = '0;
  logic [7:0] far_char, ch, c2;
  logic [15:0] q, d;
  logic [3:0] chg;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] adr_tab [9] = '{`UHRI_ADR_IEN, `UHRI_ADR_IIR, `UHRI_ADR_LCR,
    `UHRI_ADR_MCR, `UHRI_ADR_LSR, `UHRI_ADR_MSR, `UHRI_ADR_SCR, `UHRI_ADR_FBR,
    `UHRI_ADR_DIV};
  logic [15:0] rst_tab [9] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0060,
    16'h0000, 16'h0000, 16'h0000, 16'h0001};
  logic [15:0] msk_tab [9] = '{16'h003F, 16'h0000, 16'h007F, 16'h001F, 16'h0000,
    16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  always #25 clk_i = ~clk_i;

  uhri_top uhri_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_evt_i(rx_evt_i),
    .modem_i(modem_i), .txd_o(txd_o), .irq_o(irq_o), .rx_dma_req_o(rx_dma_req_o),
    .tx_dma_req_o(tx_dma_req_o));
  uhri_far_end uhri_far_end_inst (.clk_i(clk_i), .line_i(txd_o), .char_o(far_char),
    .got_o(far_got), .frame_err_o(far_err));

  ////////////////////////////////////////
  function automatic logic [15:0] iir_exp(logic [1:0] cause);
    return {13'h0000, cause, 1'b0};
  endfunction

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_reg(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(string what, logic exp, logic got);
    cmp_reg(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic bus(logic we, logic [31:0] adr, logic [15:0] dat);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, dat};
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) begin
      @(posedge clk_i);
    end
    if (wb_ack_o !== 1'b1) begin
      cmp_bit("ack", 1'b1, wb_ack_o);
      conclude();
    end
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(string what, logic [31:0] adr, logic [15:0] exp);
    bus(1'b0, adr, 16'h0000);
    cmp_reg(what, exp, q);
  endtask

  task automatic get_char(logic [7:0] exp);
    int k;
    for (k = 0; k < 600 && far_got !== 1'b1; k++) begin
      @(posedge clk_i);
    end
    if (far_got !== 1'b1) begin
      cmp_bit("far_got", 1'b1, far_got);
      conclude();
    end
    cmp_reg("char", {8'h00, exp}, {8'h00, far_char});
    cmp_bit("stop", 1'b0, far_err);
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(63589));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("rx_buffer", `UHRI_ADR_DATA, 16'h0000);
    foreach (adr_tab[i]) begin
      chk("reset", adr_tab[i], rst_tab[i]);
    end
    foreach (adr_tab[i]) begin
      d = 16'($urandom);
      bus(1'b1, adr_tab[i], d);
      if (msk_tab[i] != 16'h0000) begin
        chk("rw", adr_tab[i], d & msk_tab[i]);
      end
    end
    bus(1'b1, `UHRI_ADR_DIV, 16'h0001);
    bus(1'b1, 32'h4000_5020, 16'hFFFF);
    chk("unmapped", 32'h4000_5020, 16'h0000);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0000);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0002);
    repeat (2) @(posedge clk_i);
    cmp_bit("irq", 1'b1, irq_o);
    chk("iir", `UHRI_ADR_IIR, iir_exp(2'b01));
    chk("iir", `UHRI_ADR_IIR, 16'h0001);
    ch = 8'($urandom);
    c2 = 8'($urandom);
    bus(1'b1, `UHRI_ADR_DATA, {8'hA5, ch});
    repeat (4) @(posedge clk_i);
    cmp_bit("irq", 1'b1, irq_o);
    bus(1'b1, `UHRI_ADR_DATA, {8'h00, c2});
    get_char(ch);
    get_char(c2);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0010);
    repeat (2) @(posedge clk_i);
    cmp_bit("tx_dma", 1'b1, tx_dma_req_o);
    cmp_bit("irq", 1'b0, irq_o);
    ch = 8'($urandom);
    rx_evt_i <= {1'b1, 4'h0, ch};
    @(posedge clk_i);
    rx_evt_i <= '0;
    repeat (3) @(posedge clk_i);
    cmp_bit("irq", 1'b0, irq_o);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0021);
    repeat (2) @(posedge clk_i);
    cmp_bit("irq", 1'b1, irq_o);
    cmp_bit("rx_dma", 1'b1, rx_dma_req_o);
    chk("iir", `UHRI_ADR_IIR, iir_exp(2'b10));
    chk("rx_buffer", `UHRI_ADR_DATA, {8'h00, ch});
    repeat (2) @(posedge clk_i);
    cmp_bit("irq", 1'b0, irq_o);
    cmp_bit("rx_dma", 1'b0, rx_dma_req_o);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0000);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0007);
    ch = 8'($urandom);
    rx_evt_i <= {1'b1, 4'h2, ch};
    @(posedge clk_i);
    rx_evt_i <= '0;
    repeat (3) @(posedge clk_i);
    chk("iir", `UHRI_ADR_IIR, iir_exp(2'b11));
    chk("line_status", `UHRI_ADR_LSR, 16'h0065);
    chk("iir", `UHRI_ADR_IIR, iir_exp(2'b10));
    chk("rx_buffer", `UHRI_ADR_DATA, {8'h00, ch});
    chk("iir", `UHRI_ADR_IIR, iir_exp(2'b01));
    chk("iir", `UHRI_ADR_IIR, 16'h0001);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0000);
    chg = 4'h1 << ($urandom % 4);
    modem_i <= {4'h6, chg};
    @(posedge clk_i);
    modem_i <= {4'h6, 4'h0};
    repeat (3) @(posedge clk_i);
    cmp_bit("irq", 1'b0, irq_o);
    bus(1'b1, `UHRI_ADR_IEN, 16'h0008);
    repeat (2) @(posedge clk_i);
    cmp_bit("irq", 1'b1, irq_o);
    chk("iir", `UHRI_ADR_IIR, iir_exp(2'b00));
    chk("modem_status", `UHRI_ADR_MSR, {8'h00, 4'h6, chg});
    repeat (2) @(posedge clk_i);
    cmp_bit("irq", 1'b0, irq_o);
    conclude();
  end
endmodule

bind uhri_top uhri_monitor uhri_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o), .irq_o(irq_o),
  .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o));

/* File: sim/uhri_far_end.sv */
// Remote serial receiver: decodes start, eight data bits and stop from the line.
// Assumes 16 clocks per bit, that is baud_divider left at its reset value 1.
`timescale 1ns/1ps

module uhri_far_end (
  // Clock and line.
  input wire logic clk_i,
  input wire logic line_i,
  // Decoded character.
  output logic [7:0] char_o,
  output logic got_o,
  output logic frame_err_o
);
  initial begin
    char_o = 8'h00;
    got_o = 1'b0;
    frame_err_o = 1'b0;
  end

  // Samples each bit in its middle, least significant bit first.
  always begin
    @(negedge line_i);
    repeat (8) @(posedge clk_i);
    if (!line_i) begin
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge clk_i);
        char_o[i] <= line_i;
      end
      repeat (16) @(posedge clk_i);
      frame_err_o <= !line_i;
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  end
endmodule

/* File: sim/uhri_monitor.sv */
// Checker of the serial port register front end, seeing only its top ports.
// Assumes a bind to uhri_top, one clock domain and baud_divider at 1 or more.
`timescale 1ns/1ps
`include "uhri_params.svh"

module uhri_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Line, interrupt and requests.
  input wire logic txd_o,
  input wire logic irq_o,
  input wire logic rx_dma_req_o,
  input wire logic tx_dma_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 32'h4000_5020
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rx_upper: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `UHRI_ADR_DATA
    |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("receive upper byte not zero");
  a_ien_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `UHRI_ADR_IEN
    |-> wb_dat_o[31:6] == 26'h000_0000)
    else $error("enable reserved bits set");
  a_iir_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `UHRI_ADR_IIR
    |-> wb_dat_o[31:3] == 29'h0000_0000)
    else $error("identify reserved bits set");
  a_pend_irq: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `UHRI_ADR_IIR
    && !wb_dat_o[0] |-> irq_o)
    else $error("pending shown without interrupt");
  a_bit_width: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("low bit shorter than half period");
  a_rst_quiet: assert property ($fell(rst_i) |-> !irq_o && !wb_ack_o && txd_o
    && !rx_dma_req_o && !tx_dma_req_o)
    else $error("outputs active after reset");
endmodule
